// ==== hdl/power_monitor_port.v ====
// serial slave port and alarm logic of the power monitor
// Operation
// - bus limit word: upper limit high byte, lower low byte, 256mV steps
// - warning flags stick until written with one
// - flags: bus under D0, bus over D1, shunt under D2, shunt over D3
// - bus reading below bus lower limit sets bus under flag
// - bus reading above bus upper limit sets bus over flag
// - shunt reading below shunt lower limit sets shunt under flag
// - shunt reading above shunt upper limit sets shunt over flag
// - force alert bit D8 drives the alert pin low
// - with alert enable D7, any set flag drives alert pin low
// - external timebase bit D6 makes pin an input, stops oscillator
// - internal clock is pin frequency over (divider+1), bits 5..0
// - device is slave only; master starts transfers and clocks
// - every register transfer is two bytes, high byte first
// - sda changes only with scl low; else start or stop
// - ignore bus until start; ignore start during power-up
// - after power-up sda driver is released
// - stop returns the port to standby
// - address 100 plus four bits decoded from two four-way straps
// - eighth bit of address byte: one read, zero write
// - acknowledge address byte only on a match
// - word pointer resets to 00h
// - each new reading compared with its limits exactly once
// - write: slave, pointer, high, low bytes each acknowledged
// - pointer advances after each read word the master acknowledges; above 09h reads 0000h
// - broadcast address 0111111 accepted for writes
`include "power_monitor_map.vh"
module power_monitor_port (
  // clock and reset
  input wire mclk,
  input wire reset,
  input wire clk_en,
  input wire power_up_busy,
  // serial bus pins
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  // address straps, each tied to gnd, vcc, sda or scl
  input wire [1:0] address_strap_low,
  input wire [1:0] address_strap_high,
  // alert or timebase pin
  input wire alert_or_timebase_pin_in,
  output wire alert_or_timebase_pin_out,
  output wire alert_or_timebase_pin_oe,
  // converter readings
  input wire reading_valid,
  input wire [7:0] bus_reading,
  input wire signed [7:0] shunt_reading,
  input wire [15:0] shunt_limit_pair,
  // clocking status
  output wire oscillator_enable,
  output wire timebase_tick
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_ACK = 3'h2;
  localparam ST_RECV = 3'h3;
  localparam ST_SEND = 3'h4;
  localparam ST_MACK = 3'h5;
  localparam ST_HOLD = 3'h6;
  reg [1:0] scl_s1_ff, sda_s1_ff, tb_s1_ff;
  reg [1:0] scl_s2_ff, sda_s2_ff, tb_s2_ff;
  reg scl_prev_ff, sda_prev_ff;
  reg [2:0] state_ff, nxt_state;
  reg [2:0] bitcnt_ff;
  reg [7:0] shift_ff;
  reg [1:0] bytecnt_ff;
  reg read_ff, drive_ff, match_ff;
  reg [7:0] pointer_ff;
  reg [15:0] bus_limit_ff;
  reg [3:0] warn_ff;
  reg [8:0] aux_ff;
  reg [7:0] data_hi_ff;
  reg [15:0] tx_ff;
  reg [6:0] own_addr_ff;
  reg tb_level_ff;
  wire scl, sda, scl_rise, scl_fall, start_cond, stop_cond;
  wire [3:0] warn_set;
  wire [15:0] reg_rd;
  wire [15:0] reg_nx;
  // two-stage synchronisers for pins
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : sync
      always @(posedge mclk)
      begin
        if (reset)
        begin
          scl_s1_ff[g] <= 1'b1;
          sda_s1_ff[g] <= 1'b1;
          tb_s1_ff[g] <= 1'b1;
        end
        else if (clk_en)
        begin
          scl_s1_ff[g] <= (g == 0) ? scl_in : scl_s1_ff[0];
          sda_s1_ff[g] <= (g == 0) ? sda_in : sda_s1_ff[0];
          tb_s1_ff[g] <= (g == 0) ? alert_or_timebase_pin_in : tb_s1_ff[0];
        end
      end
    end
  endgenerate
  always @*
  begin
    scl_s2_ff = scl_s1_ff;
    sda_s2_ff = sda_s1_ff;
    tb_s2_ff = tb_s1_ff;
  end
  assign scl = scl_s2_ff[1];
  assign sda = sda_s2_ff[1];
  assign scl_rise = scl & ~scl_prev_ff;
  assign scl_fall = ~scl & scl_prev_ff;
  // sda edge while scl high is start or stop
  assign start_cond = scl & scl_prev_ff & sda_prev_ff & ~sda;
  assign stop_cond = scl & scl_prev_ff & ~sda_prev_ff & sda;
  // strap decode: gnd 0, vcc 1, sda 2, scl 3
  function [1:0] strap_code;
    input [1:0] s;
    begin
      case (s)
        `STRAP_GND: strap_code = 2'h0;
        `STRAP_VCC: strap_code = 2'h1;
        `STRAP_SDA: strap_code = 2'h2;
        default: strap_code = 2'h3;
      endcase
    end
  endfunction
  // register read mux
  function [15:0] read_word;
    input [7:0] ptr;
    input [15:0] bl;
    input [15:0] sl;
    input [3:0] w;
    input [8:0] a;
    begin
      case (ptr)
        `SHUNT_LIMIT_OFFSET: read_word = sl;
        `BUS_LIMIT_OFFSET: read_word = bl;
        `WARN_FLAGS_OFFSET: read_word = {12'h000, w};
        `AUX_CONTROL_OFFSET: read_word = {7'h00, a};
        default: read_word = 16'h0000;
      endcase
    end
  endfunction
  assign reg_rd = read_word(pointer_ff, bus_limit_ff, shunt_limit_pair,
    warn_ff, aux_ff);
  assign reg_nx = read_word(pointer_ff + 8'h01, bus_limit_ff,
    shunt_limit_pair, warn_ff, aux_ff);
  // limit compares, once per valid reading
  assign warn_set[`WARN_BUS_UNDER] = reading_valid &
    (bus_reading < bus_limit_ff[7:0]);
  assign warn_set[`WARN_BUS_OVER] = reading_valid &
    (bus_reading > bus_limit_ff[15:8]);
  assign warn_set[`WARN_SHUNT_UNDER] = reading_valid &
    (shunt_reading < $signed(shunt_limit_pair[7:0]));
  assign warn_set[`WARN_SHUNT_OVER] = reading_valid &
    (shunt_reading > $signed(shunt_limit_pair[15:8]));
  // byte state machine
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: nxt_state = ST_IDLE;
      ST_HOLD: if (scl_fall)
        nxt_state = ST_ADDR;
      ST_ADDR: if (scl_fall && bitcnt_ff == 3'h0)
        nxt_state = match_ff ? ST_ACK : ST_IDLE;
      ST_ACK: if (scl_fall)
        nxt_state = read_ff ? ST_SEND : ST_RECV;
      ST_RECV: if (scl_fall && bitcnt_ff == 3'h0)
        nxt_state = ST_ACK;
      ST_SEND: if (scl_fall && bitcnt_ff == 3'h0)
        nxt_state = ST_MACK;
      ST_MACK: if (scl_fall)
        nxt_state = sda_prev_ff ? ST_IDLE : ST_SEND;
      default: nxt_state = ST_IDLE;
    endcase
    if (stop_cond)
      nxt_state = ST_IDLE;
    if (start_cond && !power_up_busy)
      nxt_state = ST_HOLD;
  end
  always @(posedge mclk)
  begin
    if (reset)
    begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
      state_ff <= ST_IDLE;
      bitcnt_ff <= 3'h7;
      shift_ff <= 8'h00;
      bytecnt_ff <= 2'h0;
      read_ff <= 1'b0;
      match_ff <= 1'b0;
      drive_ff <= 1'b0;
      pointer_ff <= `POINTER_RESET;
      bus_limit_ff <= `LIMIT_RESET;
      warn_ff <= 4'h0;
      aux_ff <= `AUX_RESET;
      data_hi_ff <= 8'h00;
      tx_ff <= 16'h0000;
      own_addr_ff <= 7'h00;
      tb_level_ff <= 1'b1;
    end
    else if (clk_en)
    begin
      scl_prev_ff <= scl;
      sda_prev_ff <= sda;
      tb_level_ff <= tb_s2_ff[1];
      state_ff <= nxt_state;
      own_addr_ff <= {`SLAVE_ADDR_TOP, strap_code(address_strap_high),
        strap_code(address_strap_low)};
      // set wins over a simultaneous write-one clear
      warn_ff <= warn_set | (warn_ff & ~((state_ff == ST_RECV && scl_fall &&
        bitcnt_ff == 3'h0 && bytecnt_ff == 2'h2 &&
        pointer_ff == `WARN_FLAGS_OFFSET) ? shift_ff[3:0] : 4'h0));
      if (start_cond)
      begin
        bitcnt_ff <= 3'h7;
        bytecnt_ff <= 2'h0;
        drive_ff <= 1'b0;
      end
      // sample on rising scl, msb first
      if (scl_rise && (state_ff == ST_ADDR || state_ff == ST_RECV))
      begin
        shift_ff <= {shift_ff[6:0], sda};
        if (state_ff == ST_ADDR && bitcnt_ff == 3'h0)
        begin
          read_ff <= sda;
          match_ff <= (shift_ff[6:0] == own_addr_ff) ||
            (shift_ff[6:0] == `BROADCAST_ADDR && !sda);
        end
      end
      if (scl_fall)
      begin
        case (state_ff)
          ST_ADDR, ST_RECV:
          begin
            bitcnt_ff <= bitcnt_ff - 3'h1;
            if (bitcnt_ff == 3'h0)
            begin
              drive_ff <= state_ff == ST_RECV || match_ff;
              if (state_ff == ST_RECV)
              begin
                bytecnt_ff <= bytecnt_ff == 2'h2 ? 2'h1 : bytecnt_ff + 2'h1;
                if (bytecnt_ff == 2'h0)
                  pointer_ff <= shift_ff;
                else if (bytecnt_ff == 2'h1)
                  data_hi_ff <= shift_ff;
                else
                begin
                  if (pointer_ff == `BUS_LIMIT_OFFSET)
                    bus_limit_ff <= {data_hi_ff, shift_ff};
                  if (pointer_ff == `AUX_CONTROL_OFFSET)
                    aux_ff <= {data_hi_ff[0], shift_ff};
                end
              end
            end
          end
          ST_ACK:
          begin
            bitcnt_ff <= 3'h7;
            drive_ff <= read_ff && !reg_rd[15];
            tx_ff <= {reg_rd[14:0], 1'b0};
            if (read_ff)
              bytecnt_ff <= 2'h0;
          end
          ST_SEND:
          begin
            bitcnt_ff <= bitcnt_ff - 3'h1;
            drive_ff <= bitcnt_ff != 3'h0 && !tx_ff[15];
            if (bitcnt_ff != 3'h0)
              tx_ff <= {tx_ff[14:0], 1'b0};
          end
          ST_MACK:
          begin
            bitcnt_ff <= 3'h7;
            if (!sda_prev_ff)
            begin
              if (bytecnt_ff == 2'h0)
              begin
                bytecnt_ff <= 2'h1;
                drive_ff <= !tx_ff[15];
                tx_ff <= {tx_ff[14:0], 1'b0};
              end
              else
              begin
                bytecnt_ff <= 2'h0;
                pointer_ff <= pointer_ff + 8'h01;
                drive_ff <= read_ff && !reg_nx[15];
                tx_ff <= {reg_nx[14:0], 1'b0};
              end
            end
          end
          default: drive_ff <= 1'b0;
        endcase
      end
      if (stop_cond)
        drive_ff <= 1'b0;
    end
  end
  // open-drain sda, driven low only; master owns scl
  assign sda_out = 1'b0;
  assign sda_oe = drive_ff;
  // alert pin low on force or enabled warning, input in timebase mode
  assign alert_or_timebase_pin_out = 1'b0;
  assign alert_or_timebase_pin_oe = !aux_ff[`AUX_EXT_TIMEBASE] &&
    (aux_ff[`AUX_FORCE_ALERT] ||
    (aux_ff[`AUX_ALERT_ENABLE] && |warn_ff));
  assign oscillator_enable = !aux_ff[`AUX_EXT_TIMEBASE];
  timebase_divider u_div (
    .mclk(mclk),
    .reset(reset),
    .clk_en(clk_en),
    .enable(aux_ff[`AUX_EXT_TIMEBASE]),
    .div(aux_ff[`AUX_DIV_MSB:0]),
    .tb_level(tb_level_ff),
    .tick_ff(timebase_tick)
  );
endmodule // power_monitor_port

// ==== hdl/power_monitor_map.vh ====
// register offsets, fields and constants of the monitor slave port
`ifndef POWER_MONITOR_MAP_VH
`define POWER_MONITOR_MAP_VH
`define SHUNT_LIMIT_OFFSET 8'h06
`define BUS_LIMIT_OFFSET 8'h07
`define WARN_FLAGS_OFFSET 8'h08
`define AUX_CONTROL_OFFSET 8'h09
`define LAST_VALID_OFFSET 8'h09
`define POINTER_RESET 8'h00
`define WARN_BUS_UNDER 0
`define WARN_BUS_OVER 1
`define WARN_SHUNT_UNDER 2
`define WARN_SHUNT_OVER 3
`define AUX_FORCE_ALERT 8
`define AUX_ALERT_ENABLE 7
`define AUX_EXT_TIMEBASE 6
`define AUX_DIV_MSB 5
`define BUS_LIMIT_STEP_MV 256
`define SLAVE_ADDR_TOP 3'h4
`define BROADCAST_ADDR 7'h3f
`define LIMIT_RESET 16'h0000
`define AUX_RESET 9'h000
`define STRAP_GND 2'h0
`define STRAP_VCC 2'h1
`define STRAP_SDA 2'h2
`define STRAP_SCL 2'h3
`endif

// ==== hdl/timebase_divider.v ====
// divides the external timebase by (div+1) into a tick
module timebase_divider (
  // clock and control
  input wire mclk,
  input wire reset,
  input wire clk_en,
  input wire enable,
  input wire [5:0] div,
  // synchronised timebase input and tick output
  input wire tb_level,
  output reg tick_ff
);
  reg tb_prev_ff;
  reg [6:0] count_ff;
  wire tb_rise;
  assign tb_rise = tb_level & ~tb_prev_ff;
  always @(posedge mclk)
  begin
    if (reset)
    begin
      tb_prev_ff <= 1'b1;
      count_ff <= 7'h00;
      tick_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      tb_prev_ff <= tb_level;
      tick_ff <= 1'b0;
      if (!enable)
        count_ff <= 7'h00;
      else if (tb_rise)
      begin
        // one internal period per div+1 input periods, counted on rising edges
        if (count_ff >= {1'b0, div})
        begin
          count_ff <= 7'h00;
          tick_ff <= 1'b1;
        end
        else
          count_ff <= count_ff + 7'h01;
      end
    end
  end
endmodule // timebase_divider

// ==== test/power_monitor_properties.sv ====
// concurrent checks on the pins of the monitor slave port
module power_monitor_properties (
  // clock and reset
  input logic mclk,
  input logic reset,
  // watched pins
  input logic power_up_busy,
  input logic scl_in,
  input logic sda_oe,
  input logic reading_valid,
  input logic alert_or_timebase_pin_oe,
  input logic oscillator_enable,
  input logic timebase_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  a_reset_release: assert property (disable iff (1'b0)
    reset |=> !sda_oe && !alert_or_timebase_pin_oe && oscillator_enable)
    else $error("pins not idle after reset");
  a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda drive changed with scl high");
  a_busy_no_ack: assert property ($rose(sda_oe) |-> !power_up_busy)
    else $error("answer given during power-up");
  a_alert_clear: assert property (
    $fell(alert_or_timebase_pin_oe) |-> !scl_in)
    else $error("alert released outside a write");
  a_alert_cause: assert property ($rose(alert_or_timebase_pin_oe) |->
    !scl_in || $past(reading_valid) || $past(reading_valid, 2) ||
    $past(reading_valid, 3))
    else $error("alert raised without cause");
  a_osc_on_write: assert property (
    $changed(oscillator_enable) |-> !scl_in)
    else $error("oscillator changed outside a write");
  a_pin_input: assert property (
    !oscillator_enable |-> !alert_or_timebase_pin_oe)
    else $error("pin driven while timebase input");
  a_tick_pulse: assert property (timebase_tick |=> !timebase_tick)
    else $error("tick longer than one cycle");
  a_tick_source: assert property (
    timebase_tick |-> !oscillator_enable)
    else $error("tick without external timebase");
  c_ack: cover property ($rose(sda_oe));
  c_alert: cover property ($rose(alert_or_timebase_pin_oe));
  c_tick: cover property (timebase_tick);
endmodule // power_monitor_properties
bind power_monitor_port power_monitor_properties u_props (.mclk(mclk),
  .reset(reset), .power_up_busy(power_up_busy), .scl_in(scl_in),
  .sda_oe(sda_oe), .reading_valid(reading_valid),
  .alert_or_timebase_pin_oe(alert_or_timebase_pin_oe),
  .oscillator_enable(oscillator_enable), .timebase_tick(timebase_tick));

// ==== test/i2c_master_model.sv ====
// bus master model driving the two serial lines
module i2c_master_model (
  // clock and line level
  input logic mclk,
  input logic sda_line,
  // open-drain drives, one is released
  output logic scl_drv,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 8;
  initial scl_drv = 1;
  initial sda_drv = 1;
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // master alone makes starts and clocks
  task automatic start;
    sda_drv = 1;
    wt(HALF);
    scl_drv = 1;
    wt(HALF);
    sda_drv = 0;
    wt(HALF);
    scl_drv = 0;
    wt(HALF);
  endtask
  task automatic stop;
    sda_drv = 0;
    wt(HALF);
    scl_drv = 1;
    wt(HALF);
    sda_drv = 1;
    wt(HALF);
  endtask
  // eight bits msb first, then the ninth bit
  task automatic xfer(input logic [7:0] d, input logic ak,
                      output logic [7:0] q, output logic got);
    logic [8:0] o;
    logic [8:0] v;
    o = {d, ak};
    for (int i = 8; i >= 0; i--)
    begin
      sda_drv = o[i];
      wt(HALF);
      scl_drv = 1;
      wt(HALF);
      v[i] = sda_line;
      scl_drv = 0;
      wt(2);
    end
    q = v[8:1];
    got = !v[0];
  endtask
endmodule // i2c_master_model

// ==== test/test_power_monitor_port.sv ====
// self-checking bench of the monitor slave port
module test_power_monitor_port;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] BL = 16'hc040;
  logic mclk = 0;
  logic reset = 1;
  logic busy = 0;
  logic rv = 0;
  logic tbp = 1;
  logic [7:0] br = 8'h00;
  logic [7:0] sr = 8'h00;
  logic [15:0] slp = 16'h10f0;
  logic [1:0] sl = 2'h0;
  logic [1:0] sh = 2'h0;
  logic [7:0] lf = 8'h12;
  logic [7:0] q;
  logic ok;
  int err_total = 0;
  int n_checks = 0;
  int nt = 0;
  wire scl;
  wire sd_m;
  wire sda_oe;
  wire a_oe;
  wire osc;
  wire tick;
  wire so;
  wire ao;
  wire sda = sd_m & (sda_oe ? so : 1'b1);
  wire apin = a_oe ? ao : tbp;
  wire [6:0] me = {3'h4, sh, sl};
  initial forever #25 mclk = !mclk;
  always @(posedge mclk) if (tick === 1'b1) nt <= nt + 1;
  i2c_master_model u_host (.mclk(mclk), .sda_line(sda), .scl_drv(scl),
    .sda_drv(sd_m));
  power_monitor_port u_dut (.mclk(mclk), .reset(reset), .clk_en(1'b1),
    .power_up_busy(busy), .scl_in(scl), .sda_in(sda), .sda_out(so),
    .sda_oe(sda_oe), .address_strap_low(sl), .address_strap_high(sh),
    .alert_or_timebase_pin_in(apin), .alert_or_timebase_pin_out(ao),
    .alert_or_timebase_pin_oe(a_oe), .reading_valid(rv),
    .bus_reading(br), .shunt_reading(sr), .shunt_limit_pair(slp),
    .oscillator_enable(osc), .timebase_tick(tick));
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic [3:0] flg(input logic [7:0] b, input logic [7:0] s);
    return {$signed(s) > $signed(slp[15:8]), $signed(s) < $signed(slp[7:0]),
      b > BL[15:8], b < BL[7:0]};
  endfunction
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] s);
    n_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p,
                    input logic [15:0] d);
    logic k0, k1, k2, k3;
    u_host.start();
    u_host.xfer({a, 1'b0}, 1'b1, q, k0);
    u_host.xfer(p, 1'b1, q, k1);
    u_host.xfer(d[15:8], 1'b1, q, k2);
    u_host.xfer(d[7:0], 1'b1, q, k3);
    u_host.stop();
    ok = k0 & k1 & k2 & k3;
  endtask
  task automatic rd(input logic [7:0] p, input int n, input logic [15:0] e0,
                    input logic [15:0] e1);
    logic [7:0] h;
    logic [7:0] l;
    logic a;
    u_host.start();
    u_host.xfer({me, 1'b0}, 1'b1, q, a);
    u_host.xfer(p, 1'b1, q, a);
    u_host.start();
    u_host.xfer({me, 1'b1}, 1'b1, q, a);
    for (int i = 0; i < n; i++)
    begin
      u_host.xfer(8'hff, 1'b0, h, a);
      u_host.xfer(8'hff, i == n - 1, l, a);
      chk("word", i == 0 ? e0 : e1, {h, l});
    end
    u_host.stop();
  endtask
  task automatic conv(input logic [7:0] b, input logic [7:0] s);
    br = b;
    sr = s;
    rv = 1;
    @(posedge mclk);
    #1 rv = 0;
  endtask
  initial
  begin
    repeat (60000) @(posedge mclk);
    err_total++;
    stop_test();
  end
  initial
  begin
    logic [15:0] v;
    logic [3:0] fe;
    int n0;
    lf = nx(lf);
    sl = lf[1:0];
    sh = lf[5:4];
    repeat (12) @(posedge mclk);
    #1 reset = 0;
    repeat (6) @(posedge mclk);
    #1;
    rd(8'h07, 2, 16'h0000, 16'h0000);
    rd(8'h06, 1, slp, 16'h0000);
    busy = 1;
    wr(me, 8'h07, 16'h1234);
    busy = 0;
    chk("busy ack", 16'h0000, {15'h0, ok});
    wr(me ^ 7'h08, 8'h07, 16'h5678);
    chk("other ack", 16'h0000, {15'h0, ok});
    rd(8'h07, 1, 16'h0000, 16'h0000);
    repeat (3)
    begin
      lf = nx(lf);
      v = {lf, nx(lf)};
      lf = nx(lf);
      wr(me, 8'h07, v);
      chk("write ack", 16'h0001, {15'h0, ok});
      rd(8'h07, 1, v, 16'h0000);
    end
    wr(7'h3f, 8'h07, BL);
    chk("broadcast ack", 16'h0001, {15'h0, ok});
    rd(8'h07, 1, BL, 16'h0000);
    wr(me, 8'h09, 16'h0080);
    fe = 4'h0;
    for (int i = 0; i < 8; i++)
    begin
      if (i < 2)
        conv(i ? BL[15:8] : BL[7:0], i ? slp[15:8] : slp[7:0]);
      else
        conv(lf, nx(lf));
      lf = nx(nx(lf));
      fe = fe | flg(br, sr);
      rd(8'h08, 1, {12'h000, fe}, 16'h0000);
      chk("alert", {15'h0, fe != 4'h0}, {15'h0, a_oe});
      chk("alert pin", {15'h0, fe == 4'h0}, {15'h0, apin});
    end
    wr(me, 8'h08, 16'hfff1);
    rd(8'h08, 1, {12'h000, fe & 4'he}, 16'h0000);
    wr(me, 8'h08, 16'h000f);
    chk("alert off", 16'h0000, {15'h0, a_oe});
    wr(me, 8'h09, 16'h0100);
    chk("force", 16'h0001, {15'h0, a_oe});
    rd(8'h08, 2, 16'h0000, 16'h0100);
    rd(8'h09, 2, 16'h0100, 16'h0000);
    wr(me, 8'h09, 16'hffff);
    rd(8'h09, 1, 16'h01ff, 16'h0000);
    chk("pin input", 16'h0000, {14'h0, osc, a_oe});
    wr(me, 8'h09, 16'h0043);
    n0 = nt;
    repeat (32)
    begin
      repeat (4) @(posedge mclk);
      #1 tbp = !tbp;
    end
    repeat (8) @(posedge mclk);
    #1;
    chk("ticks", 16'h0004, 16'(nt - n0));
    wr(me, 8'h09, 16'h0000);
    chk("oscillator", 16'h0001, {15'h0, osc});
    stop_test();
  end
endmodule // test_power_monitor_port
